// ### tw_master.sv
// Two-wire single-master controller with an AHB-Lite register slave.
// Assumes one AHB-Lite master, open-drain pins resolved outside,
// and pin inputs synchronous to clk_sys.
//
// Notes on behaviour
// RULE1 - Stop after current byte or start, then clear
// RULE2 - Interrupt enable gates requests, cleared on disable
// RULE3 - Hold clock low on start, byte, address events
// RULE4 - Event summary set by any event
// RULE5 - Error summary clears on second status read
// RULE6 - Direction shows tx/rx, clears with byte flag
// RULE7 - Tx byte flag after ack; read status, write data
// RULE8 - Rx byte flag after ack; read status, read data
// RULE9 - Master bit on start request, clears after stop
// RULE10 - Start flag set; cleared by status read, address write
// RULE11 - No-ack flag, cleared by error read, no stretch
// RULE12 - Speed and divider survive disable
// RULE13 - Bus clock is 2x or 3x (divider+2)
// RULE14 - Data write starts transmit shifting
// RULE15 - First rx byte automatic, next after data read
// RULE16 - Reserved bits read zero
// RULE17 - Registers reset to zero
// RULE18 - Start request gives start or repeated start
// RULE19 - Disable clears bits and releases bus
// RULE20 - Software enables with two control writes
// RULE21 - Acknowledge driven when enabled, else none
// RULE22 - Interrupt is OR of three flags gated
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tw_master (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irq
);
  function automatic logic [tw_pkg::HIT_W-1:0] regHit(input logic [31:0] a);
    logic [tw_pkg::HIT_W-1:0] h;
    h = '0;
    h[tw_pkg::HIT_CTRL] = (a[31:2] == 30'(tw_pkg::IDX_CTRL));
    h[tw_pkg::HIT_STAT1] = (a[31:2] == 30'(tw_pkg::IDX_STAT1));
    h[tw_pkg::HIT_STAT2] = (a[31:2] == 30'(tw_pkg::IDX_STAT2));
    h[tw_pkg::HIT_CLKDIV] = (a[31:2] == 30'(tw_pkg::IDX_CLKDIV));
    h[tw_pkg::HIT_DATA] = (a[31:2] == 30'(tw_pkg::IDX_DATA));
    return h;
  endfunction

  tw_pkg::tw_state_e state;
  logic [1:0] ph;
  logic [3:0] bitCnt;
  logic [7:0] shreg;
  logic [7:0] dataReg;
  logic txMode, isAddr, rdDir;
  logic pe, startReq, ackEn, stopReq, irq_enable;
  logic fast;
  logic [tw_pkg::DIV_W-1:0] div;
  logic sb, byte_finished_flag, direction_status, af, ev2, master, armed;
  logic wrPend;
  logic [tw_pkg::HIT_W-1:0] wrHit;
  logic [tw_pkg::HIT_W-1:0] rdHit;
  logic addrPh, rdPh, rdSr1, rdSr2, rdDr, wrCr, wrDr, wrDiv;
  logic event_summary_flag, tick, run;
  logic [1:0] lastPh;
  logic [7:0] ctrlV, st1V, st2V, rdMux;

  // Bus slave decode
  assign addrPh = hsel && hready && htrans[1];
  assign rdPh = addrPh && !hwrite;
  assign rdHit = regHit(haddr);
  assign rdSr1 = rdPh && rdHit[tw_pkg::HIT_STAT1];
  assign rdSr2 = rdPh && rdHit[tw_pkg::HIT_STAT2];
  assign rdDr = rdPh && rdHit[tw_pkg::HIT_DATA];
  assign wrCr = wrPend && wrHit[tw_pkg::HIT_CTRL];
  assign wrDr = wrPend && wrHit[tw_pkg::HIT_DATA];
  assign wrDiv = wrPend && wrHit[tw_pkg::HIT_CLKDIV];

  assign event_summary_flag = sb || byte_finished_flag || af || ev2; // [RULE4] [RULE5]
  assign lastPh = fast ? 2'(tw_pkg::PH_FAST - 1) : 2'(tw_pkg::PH_STD - 1); // [RULE13]
  assign run = (state == tw_pkg::S_START) || (state == tw_pkg::S_SHIFT) || (state == tw_pkg::S_STOP);

  tw_tick #(
    .DIV_W(tw_pkg::DIV_W)
  ) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(run),
    .div(div),
    .tick(tick)
  ); // [RULE13]

  // Read view; reserved bits stay zero
  always_comb begin
    ctrlV = '0; // [RULE16]
    ctrlV[tw_pkg::CTRL_PE] = pe;
    ctrlV[tw_pkg::CTRL_START] = startReq;
    ctrlV[tw_pkg::CTRL_ACK] = ackEn;
    ctrlV[tw_pkg::CTRL_STOP] = stopReq;
    ctrlV[tw_pkg::CTRL_ITE] = irq_enable;
    st1V = '0;
    st1V[tw_pkg::ST1_EVF] = event_summary_flag;
    st1V[tw_pkg::ST1_TRA] = direction_status;
    st1V[tw_pkg::ST1_BTF] = byte_finished_flag;
    st1V[tw_pkg::ST1_MST] = master;
    st1V[tw_pkg::ST1_SB] = sb;
    st2V = '0;
    st2V[tw_pkg::ST2_AF] = af;
    rdMux = '0;
    unique case (1'b1)
      rdHit[tw_pkg::HIT_CTRL]: rdMux = ctrlV;
      rdHit[tw_pkg::HIT_STAT1]: rdMux = st1V;
      rdHit[tw_pkg::HIT_STAT2]: rdMux = st2V;
      rdHit[tw_pkg::HIT_CLKDIV]: rdMux = {fast, div};
      rdHit[tw_pkg::HIT_DATA]: rdMux = dataReg;
      default: rdMux = '0;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= tw_pkg::HRESP_OKAY;
      wrPend <= 1'b0;
      wrHit <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= tw_pkg::HRESP_OKAY;
      wrPend <= addrPh && hwrite;
      wrHit <= regHit(haddr);
      if (rdPh) begin
        hrdata <= {24'h00_0000, rdMux};
      end else begin
        hrdata <= '0;
      end
    end
  end

  // Enable and clock configuration, untouched by disable
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pe <= 1'b0; // [RULE17]
      fast <= 1'b0;
      div <= '0;
    end else begin
      if (wrCr) begin
        pe <= hwdata[tw_pkg::CTRL_PE];
      end
      if (wrDiv) begin
        fast <= hwdata[tw_pkg::DIV_FAST]; // [RULE12]
        div <= hwdata[tw_pkg::DIV_W-1:0];
      end
    end
  end

  // Status-read arming for the clear sequences
  always_ff @(posedge clk_sys) begin
    if (!nrst || !pe) begin
      armed <= 1'b0;
    end else if (rdSr1) begin
      armed <= 1'b1;
    end else if (wrDr || rdDr || wrCr) begin
      armed <= 1'b0;
    end
  end

  // Transfer engine, flags and hardware-cleared control bits
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= tw_pkg::S_IDLE; // [RULE17]
      ph <= '0;
      bitCnt <= '0;
      shreg <= '0;
      dataReg <= tw_pkg::RESET_VAL;
      txMode <= 1'b0;
      isAddr <= 1'b0;
      rdDir <= 1'b0;
      startReq <= 1'b0;
      ackEn <= 1'b0;
      stopReq <= 1'b0;
      irq_enable <= 1'b0;
      sb <= 1'b0;
      byte_finished_flag <= 1'b0;
      direction_status <= 1'b0;
      af <= 1'b0;
      ev2 <= 1'b0;
      master <= 1'b0;
    end else begin
      if (wrDr) begin
        dataReg <= hwdata[7:0];
      end
      if (!pe) begin
        // First enabling write sets nothing else
        state <= tw_pkg::S_IDLE; // [RULE19] [RULE20]
        startReq <= 1'b0; // [RULE18]
        stopReq <= 1'b0; // [RULE1]
        ackEn <= 1'b0;
        irq_enable <= 1'b0; // [RULE2]
        sb <= 1'b0;
        byte_finished_flag <= 1'b0;
        direction_status <= 1'b0; // [RULE6]
        af <= 1'b0;
        ev2 <= 1'b0;
        master <= 1'b0; // [RULE9]
      end else begin
        if (wrCr) begin
          startReq <= hwdata[tw_pkg::CTRL_START];
          ackEn <= hwdata[tw_pkg::CTRL_ACK];
          stopReq <= hwdata[tw_pkg::CTRL_STOP];
          irq_enable <= hwdata[tw_pkg::CTRL_ITE]; // [RULE2]
        end
        if (rdSr2) begin
          af <= 1'b0; // [RULE5] [RULE11]
        end
        unique case (state)
          tw_pkg::S_IDLE: begin
            if (startReq && sclIn && sdaIn) begin
              state <= tw_pkg::S_START; // [RULE18]
              ph <= 2'd1;
              master <= 1'b1; // [RULE9]
            end
          end
          tw_pkg::S_START: begin
            if (tick) begin
              if (ph == 2'(tw_pkg::SEQ_LAST)) begin
                sb <= 1'b1; // [RULE10]
                startReq <= 1'b0; // [RULE18]
                ph <= '0;
                state <= stopReq ? tw_pkg::S_STOP : tw_pkg::S_HOLD; // [RULE1]
              end else begin
                ph <= ph + 1'b1;
              end
            end
          end
          tw_pkg::S_HOLD: begin
            if (sb && armed && wrDr) begin
              sb <= 1'b0; // [RULE10]
              shreg <= hwdata[7:0];
              rdDir <= hwdata[0];
              isAddr <= 1'b1;
              txMode <= 1'b1;
              state <= tw_pkg::S_SHIFT;
              ph <= '0;
              bitCnt <= '0;
            end else if (ev2 && armed && wrCr) begin
              ev2 <= 1'b0;
              if (rdDir) begin
                txMode <= 1'b0; // [RULE15]
                state <= tw_pkg::S_SHIFT;
                ph <= '0;
                bitCnt <= '0;
              end else begin
                byte_finished_flag <= 1'b1; // [RULE7]
                direction_status <= 1'b1;
              end
            end else if (byte_finished_flag && direction_status && armed && wrDr) begin
              byte_finished_flag <= 1'b0; // [RULE7]
              direction_status <= 1'b0; // [RULE6]
              shreg <= hwdata[7:0]; // [RULE14]
              txMode <= 1'b1;
              state <= tw_pkg::S_SHIFT;
              ph <= '0;
              bitCnt <= '0;
            end else if (byte_finished_flag && !direction_status && armed && rdDr) begin
              byte_finished_flag <= 1'b0; // [RULE8]
              ph <= '0;
              bitCnt <= '0;
              if (stopReq) begin
                state <= tw_pkg::S_STOP; // [RULE1]
              end else if (startReq) begin
                state <= tw_pkg::S_START; // [RULE18]
              end else begin
                txMode <= 1'b0; // [RULE15]
                state <= tw_pkg::S_SHIFT;
              end
            end
          end
          tw_pkg::S_SHIFT: begin
            if (tick) begin
              if (ph != lastPh) begin
                ph <= ph + 1'b1;
              end else if (bitCnt != 4'(tw_pkg::ACK_BIT)) begin
                shreg <= {shreg[6:0], sdaIn};
                bitCnt <= bitCnt + 1'b1;
                ph <= '0;
              end else begin
                ph <= '0;
                if (!txMode) begin
                  dataReg <= shreg;
                  byte_finished_flag <= 1'b1; // [RULE8]
                  direction_status <= 1'b0; // [RULE6]
                  state <= tw_pkg::S_HOLD;
                end else if (sdaIn) begin
                  af <= 1'b1; // [RULE11]
                  isAddr <= 1'b0;
                  state <= stopReq ? tw_pkg::S_STOP : tw_pkg::S_AFWAIT;
                end else if (isAddr) begin
                  ev2 <= 1'b1; // [RULE4]
                  isAddr <= 1'b0;
                  state <= stopReq ? tw_pkg::S_STOP : tw_pkg::S_HOLD;
                end else begin
                  byte_finished_flag <= 1'b1; // [RULE7]
                  direction_status <= 1'b1; // [RULE6]
                  state <= stopReq ? tw_pkg::S_STOP : tw_pkg::S_HOLD; // [RULE1]
                end
              end
            end
          end
          tw_pkg::S_AFWAIT: begin
            ph <= '0;
            if (stopReq) begin
              state <= tw_pkg::S_STOP;
            end else if (startReq) begin
              state <= tw_pkg::S_START; // [RULE18]
            end
          end
          tw_pkg::S_STOP: begin
            if (tick) begin
              if (ph == 2'(tw_pkg::SEQ_LAST)) begin
                state <= tw_pkg::S_IDLE;
                master <= 1'b0; // [RULE9]
                stopReq <= 1'b0; // [RULE1]
                ph <= '0;
              end else begin
                ph <= ph + 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Pin drive, registered; enable high pulls the line low
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end else if (!pe) begin
      sclOe <= 1'b0; // [RULE19]
      sdaOe <= 1'b0;
    end else begin
      unique case (state)
        tw_pkg::S_IDLE: begin
          sclOe <= 1'b0;
          sdaOe <= 1'b0;
        end
        tw_pkg::S_START: begin
          sclOe <= (ph == 2'd0);
          sdaOe <= (ph == 2'(tw_pkg::SEQ_LAST));
        end
        tw_pkg::S_HOLD: begin
          sclOe <= 1'b1; // [RULE3]
        end
        tw_pkg::S_SHIFT: begin
          sclOe <= (ph != lastPh); // [RULE13]
          if (bitCnt != 4'(tw_pkg::ACK_BIT)) begin
            sdaOe <= txMode && !shreg[7]; // [RULE14]
          end else begin
            sdaOe <= !txMode && ackEn; // [RULE21]
          end
        end
        tw_pkg::S_AFWAIT: begin
          sclOe <= 1'b0; // [RULE11]
          sdaOe <= 1'b0;
        end
        tw_pkg::S_STOP: begin
          sclOe <= (ph == 2'd0);
          sdaOe <= (ph != 2'(tw_pkg::SEQ_LAST));
        end
      endcase
    end
  end

  // Single interrupt request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_enable && (sb || byte_finished_flag || af); // [RULE22] [RULE2]
    end
  end
endmodule // tw_master
`default_nettype wire

// ### tw_master_chk.sv
// Checker on the two-wire controller ports: register answers and line release.
// Assumes one AHB-Lite master and hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tw_master_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic irq
);
  logic dPh, dW, pe, irq_enable;
  logic [31:0] dA;
  logic [7:0] div, relCnt;
  wire logic rd = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Data phase of the last accepted transfer
  always_ff @(posedge clk_sys) begin
    dPh <= nrst && hsel && hready && htrans[1];
    dW <= hwrite;
    dA <= haddr;
  end
  // Shadow of control and divider writes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pe <= 1'b0;
      irq_enable <= 1'b0;
      div <= 8'h00;
    end else if (dPh && dW && dA == 32'h0000_0100) begin
      pe <= hwdata[5];
      irq_enable <= pe && hwdata[5] && hwdata[0];
    end else if (dPh && dW && dA == 32'h0000_010C) begin
      div <= hwdata[7:0];
    end
  end
  // Cycles since SCL was last pulled low
  always_ff @(posedge clk_sys) begin
    if (!nrst || sclOe) begin
      relCnt <= 8'h00;
    end else if (relCnt != 8'hFF) begin
      relCnt <= relCnt + 8'h01;
    end
  end
  a_reset_quiet: assert property ($rose(nrst) |-> hrdata == 32'h0000_0000 && hreadyout && !hresp
    && !sclOe && !sdaOe && !irq) else $error("outputs not quiet after reset");
  a_irq_gate: assert property (!irq_enable |=> !irq) else $error("irq with interrupts off");
  a_off_release: assert property (!pe ##1 !pe |-> !sclOe && !sdaOe) else $error("lines driven while off");
  a_unmapped_zero: assert property (rd && !(haddr inside {32'h0000_0100, 32'h0000_0104, 32'h0000_0108,
    32'h0000_010C, 32'h0000_0118}) |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_ctrl_read: assert property (rd && haddr == 32'h0000_0100 |=> (hrdata & 32'hFFFF_FFD0) == 32'h0000_0000
    && hrdata[5] == $past(pe) && hrdata[0] == $past(irq_enable)) else $error("control read wrong");
  a_stat1_zeros: assert property (rd && haddr == 32'h0000_0104 |=>
    (hrdata & 32'hFFFF_FF54) == 32'h0000_0000) else $error("status reserved bits set");
  a_div_keep: assert property (rd && haddr == 32'h0000_010C |=>
    hrdata == {24'h00_0000, $past(div)}) else $error("divider read wrong");
  a_scl_high: assert property ($rose(sclOe) |-> relCnt >= div[6:0] + 8'h02)
    else $error("SCL high phase too short");
endmodule // tw_master_chk
bind tw_master tw_master_chk u_tw_master_chk (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .hreadyout, .hresp, .sclOe, .sdaOe, .irq);
`default_nettype wire

// ### tw_pkg.sv
// Package for the two-wire single-master controller: register indices,
// field positions, reset values, bus phase counts and the engine states.
// Assumes nothing of its surroundings.
package tw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_STAT1 = 8'h41;
  localparam logic [7:0] IDX_STAT2 = 8'h42;
  localparam logic [7:0] IDX_CLKDIV = 8'h43;
  localparam logic [7:0] IDX_DATA = 8'h46;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Hit vector positions
  localparam int HIT_CTRL = 0;
  localparam int HIT_STAT1 = 1;
  localparam int HIT_STAT2 = 2;
  localparam int HIT_CLKDIV = 3;
  localparam int HIT_DATA = 4;
  localparam int HIT_W = 5;
  // Control fields
  localparam int CTRL_PE = 5;
  localparam int CTRL_START = 3;
  localparam int CTRL_ACK = 2;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_ITE = 0;
  // Status fields
  localparam int ST1_EVF = 7;
  localparam int ST1_TRA = 5;
  localparam int ST1_BTF = 3;
  localparam int ST1_MST = 1;
  localparam int ST1_SB = 0;
  localparam int ST2_AF = 4;
  // Clock divider fields
  localparam int DIV_FAST = 7;
  localparam int DIV_W = 7;
  // Bus clock: period = phases x (divider + offset)
  localparam int DIV_OFFSET = 2;
  localparam int PH_STD = 2;
  localparam int PH_FAST = 3;
  localparam int SEQ_LAST = 2;
  localparam int ACK_BIT = 8;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_SHIFT, S_HOLD, S_AFWAIT, S_STOP
  } tw_state_e;
endpackage

// ### tw_slave_model.sv
// Target on the two-wire bus: one address, one reply byte, optional refusal.
// Assumes scl and sda are resolved wire levels with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] REPLY = 8'hA5
) (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sdaPull,
  output logic [7:0] rxByte
);
  logic pScl = 1'b1;
  logic pSda = 1'b1;
  logic act = 1'b0;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  initial begin
    sdaPull = 1'b0;
    rxByte = 8'h00;
  end
  always @(posedge clk_sys) begin
    pScl <= scl;
    pSda <= sda;
    if (pScl && scl && pSda && !sda) begin
      act <= 1'b1;
      first <= 1'b1;
      cnt <= 4'h0;
    end else if (pScl && scl && !pSda && sda) begin
      act <= 1'b0;
      sdaPull <= 1'b0;
    end else if (act && !pScl && scl) begin
      sh <= {sh[6:0], sda};
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) first <= 1'b0;
      if (cnt == 4'h8 && !first && !rd) rxByte <= sh;
    end else if (act && pScl && !scl) begin
      if (cnt == 4'h8 && first) begin
        rd <= sh[0];
        sdaPull <= sh[7:1] == ADDR && !nack;
      end else if (cnt == 4'h8) begin
        sdaPull <= !rd && !nack;
      end else begin
        sdaPull <= rd && !first && !REPLY[3'h7 - cnt[2:0]];
      end
    end
  end
endmodule // tw_slave_model
`default_nettype wire

// ### tw_testbench.sv
// Bench for tw_master: register table, then write, read and refused transfers.
// Assumes tw_slave_model answers at 7'h2A with 8'hA5.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic w; logic [31:0] a; logic [7:0] v;} tw_row_s;
  localparam logic [31:0] A_CR = 32'h0000_0100;
  localparam logic [31:0] A_S1 = 32'h0000_0104;
  localparam logic [31:0] A_DIV = 32'h0000_010C;
  localparam logic [31:0] A_BAD = 32'h0000_0110;
  localparam tw_row_s ROWS [14] = '{'{1'b0, A_CR, 8'h00}, '{1'b0, A_S1, 8'h00}, '{1'b0, 32'h0000_0108, 8'h00},
    '{1'b0, A_DIV, 8'h00}, '{1'b0, 32'h0000_0118, 8'h00}, '{1'b1, A_CR, 8'h3F}, '{1'b0, A_CR, 8'h20},
    '{1'b1, A_CR, 8'hF5}, '{1'b0, A_CR, 8'h25}, '{1'b1, A_DIV, 8'h81}, '{1'b1, A_BAD, 8'h5A},
    '{1'b0, A_BAD, 8'h00}, '{1'b1, A_CR, 8'h00}, '{1'b0, A_DIV, 8'h81}};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic nack = 1'b0;
  logic [31:0] rdv;
  int mismatches = 0;
  int numChecks = 0;
  int cyc = 0;
  wire logic [31:0] hrdata;
  wire logic [7:0] rxByte;
  wire logic hreadyout, hresp, sclOe, sdaOe, irq, sdaPull;
  wire logic hready = hreadyout;
  wire logic sclIn = !sclOe;
  wire logic sdaIn = !(sdaOe || sdaPull);
  tw_master u_tw_master (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .sclIn, .sclOut(), .sclOe, .sdaIn, .sdaOut(), .sdaOe, .irq);
  tw_slave_model u_tw_slave_model (.clk_sys, .scl(sclIn), .sda(sdaIn), .nack, .sdaPull, .rxByte);
  always #5 clk_sys = !clk_sys;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    do bus(1'b0, A_S1, 8'h00); while ((rdv[7:0] & m) !== v);
  endtask
  task automatic open_link(input logic [7:0] c, input logic [7:0] a);
    bus(1'b1, A_CR, 8'h00);
    bus(1'b0, A_S1, 8'h00);
    chk("stat1 off", 32'h0000_0000, rdv);
    bus(1'b1, A_CR, 8'h20);
    bus(1'b1, A_CR, c);
    poll(8'h01, 8'h01);
    chk("stat1 start", 32'h0000_0083, rdv);
    chk("irq", 32'(c[0]), 32'(irq));
    chk("scl held start", 32'h0000_0001, 32'(sclOe));
    bus(1'b1, 32'h0000_0118, a);
    poll(8'h80, 8'h80);
    chk("stat1 address", 32'h0000_0082, rdv);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      bus(ROWS[i].w, ROWS[i].a, ROWS[i].v);
      if (!ROWS[i].w) chk("table read", {24'h00_0000, ROWS[i].v}, rdv);
    end
    bus(1'b1, A_DIV, 8'h01);
    open_link(8'h2D, 8'h54);
    chk("scl held address", 32'h0000_0001, 32'(sclOe));
    bus(1'b1, A_CR, 8'h25);
    poll(8'h08, 8'h08);
    chk("stat1 sent", 32'h0000_00AA, rdv);
    bus(1'b1, 32'h0000_0118, 8'h3C);
    bus(1'b1, A_CR, 8'h27);
    poll(8'h02, 8'h00);
    chk("slave byte", 32'h0000_003C, 32'(rxByte));
    bus(1'b0, A_CR, 8'h00);
    chk("stop cleared", 32'h0000_0025, rdv);
    bus(1'b1, A_DIV, 8'h81);
    open_link(8'h2C, 8'h55);
    bus(1'b1, A_CR, 8'h24);
    poll(8'h08, 8'h08);
    chk("stat1 received", 32'h0000_008A, rdv);
    bus(1'b1, A_CR, 8'h26);
    bus(1'b0, A_S1, 8'h00);
    bus(1'b0, 32'h0000_0118, 8'h00);
    chk("received byte", 32'h0000_00A5, rdv);
    poll(8'h02, 8'h00);
    nack <= 1'b1;
    open_link(8'h2D, 8'h54);
    chk("scl free", 32'h0000_0000, 32'(sclOe));
    bus(1'b0, 32'h0000_0108, 8'h00);
    chk("nack flag", 32'h0000_0010, rdv);
    bus(1'b0, A_S1, 8'h00);
    chk("event cleared", 32'h0000_0002, rdv);
    bus(1'b1, A_CR, 8'h2D);
    poll(8'h01, 8'h01);
    chk("stat1 restart", 32'h0000_0083, rdv);
    bus(1'b1, 32'h0000_0118, 8'h54);
    poll(8'h80, 8'h80);
    bus(1'b1, A_CR, 8'h27);
    poll(8'h02, 8'h00);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, A_DIV, 8'h00);
    chk("div after reset", 32'h0000_0000, rdv);
    bus(1'b0, 32'h0000_0108, 8'h00);
    chk("stat2 after reset", 32'h0000_0000, rdv);
    end_sim;
  end
endmodule // testbench
`default_nettype wire

// ### tw_tick.sv
// Phase tick divider: one-cycle pulse every (div + offset) clocks.
// Assumes run is low between sequences so phases restart aligned.
`timescale 1ns/1ps
`default_nettype none
module tw_tick #(
  parameter int DIV_W = 7
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W:0] cnt;
  logic [DIV_W:0] term;

  assign term = {1'b0, div} + (DIV_W+1)'(tw_pkg::DIV_OFFSET - 1);

  always_ff @(posedge clk_sys) begin
    if (!nrst || !run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == term) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tw_tick
`default_nettype wire
